/* File: rtl/shp_ctrl.sv */
// pause, write-protect and serial front end of the flash port
module shp_ctrl
    import shp_pkg::*;
#(
    parameter int SHIFT_BITS = shp_pkg::SHIFT_W
) (
    // clock and reset
    input  wire logic               clk,
    input  wire logic               rst,
    // pins from the host, asynchronous
    input  wire shp_pkg::shp_pins_s pins,
    // mode bits, same clock
    input  wire shp_pkg::shp_mode_s mode,
    input  wire logic               status_wr_req,
    input  wire logic               fast_program_supply_pin,
    input  wire logic               out_bit,
    // serial outputs (enable low = driving)
    output logic                    so_out,
    output logic                    so_oe_n,
    output logic                    data_line_two_oe_n,
    // state to the core
    output logic                    paused,
    output logic                    selected,
    output logic                    iface_reset,
    output logic                    status_wr_ok,
    output logic                    fast_program_ok,
    output logic                    bit_valid,
    output logic [SHIFT_BITS-1:0]   shift_data
);
    import shp_pkg::*;

    // the shifter needs at least two bits to move data along
    if (SHIFT_BITS < 2 || SHIFT_BITS > 32) begin : g_bad_width
        $error("shp_ctrl: SHIFT_BITS out of range");
    end

    // ****************************************
    // pin synchroniser
    // ****************************************
    shp_pins_s s1_r;
    shp_pins_s s2_r;
    shp_pins_s s3_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= RST_PINS; // idle levels, no false edge after reset
            s2_r <= RST_PINS;
            s3_r <= RST_PINS;
        end else begin
            s1_r <= pins;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic hold_fall;
    logic hold_rise;
    logic cs_rise;
    always_comb begin
        // edges from stage two against stage three only
        sck_rise  = s2_r.sck & ~s3_r.sck;
        sck_fall  = ~s2_r.sck & s3_r.sck;
        hold_fall = ~s2_r.pause_n & s3_r.pause_n;
        hold_rise = s2_r.pause_n & ~s3_r.pause_n;
        cs_rise   = s2_r.cs_n & ~s3_r.cs_n;
    end

    // ****************************************
    // selection and pause state
    // ****************************************
    shp_state_e state_r;
    shp_state_e state_nxt;
    logic       rst_pulse_nxt;
    always_comb begin
        state_nxt     = state_r;
        rst_pulse_nxt = 1'b0;
        case (state_r)
            SHP_IDLE: begin
                // select needs a fresh falling cs edge after reset
                if (~s2_r.cs_n & s3_r.cs_n)
                    state_nxt = SHP_ACTIVE;
            end
            SHP_ACTIVE: begin
                if (s2_r.cs_n) begin
                    state_nxt = SHP_IDLE;
                end else if (hold_fall && !s2_r.sck && !mode.four_line_command_mode
                             && !mode.quad_enable_bit) begin
                    state_nxt = SHP_PAUSED;
                end else if (hold_fall && !s2_r.sck && mode.quad_enable_bit
                             && !mode.four_line_command_mode) begin
                    state_nxt = SHP_ACTIVE;
                end
            end
            SHP_PAUSED: begin
                if (cs_rise || s2_r.cs_n) begin
                    state_nxt     = SHP_IDLE;
                    rst_pulse_nxt = 1'b1;
                end else if (hold_rise && !s2_r.sck) begin
                    state_nxt = SHP_ACTIVE;
                end
            end
            default: state_nxt = SHP_IDLE;
        endcase
    end

    // ****************************************
    // shifter
    // ****************************************
    logic [SHIFT_BITS-1:0] shift_r;
    logic [SHIFT_BITS-1:0] shift_nxt;
    logic                  bv_nxt;
    logic                  so_nxt;
    logic                  so_oe_n_nxt;
    always_comb begin
        shift_nxt   = shift_r;
        bv_nxt      = 1'b0;
        so_nxt      = so_out;
        so_oe_n_nxt = 1'b1;
        if (state_nxt == SHP_ACTIVE && state_r == SHP_ACTIVE) begin
            so_oe_n_nxt = 1'b0;
            // paused state freezes shift_r, keeping its place
            if (sck_rise) begin
                shift_nxt = {shift_r[SHIFT_BITS-2:0], s2_r.si};
                bv_nxt    = 1'b1;
            end
            if (sck_fall)
                so_nxt = out_bit;
        end
        if (state_nxt == SHP_IDLE && state_r == SHP_PAUSED)
            shift_nxt = '0;
    end

    // ****************************************
    // protection and fast program gating
    // ****************************************
    logic wr_ok_nxt;
    logic fp_ok_nxt;
    logic io2_oe_n_nxt;
    always_comb begin
        // quad mode turns protection off entirely
        wr_ok_nxt    = status_wr_req &
                       (mode.quad_enable_bit | s2_r.wp_n);
        io2_oe_n_nxt = ~(mode.quad_enable_bit & (state_nxt == SHP_ACTIVE)
                         & (state_r == SHP_ACTIVE));
        fp_ok_nxt    = fast_program_supply_pin &
                       ~mode.four_line_command_mode;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_r            <= SHP_IDLE;
            shift_r            <= '0;
            bit_valid          <= 1'b0;
            so_out             <= 1'b0;
            so_oe_n            <= 1'b1;
            data_line_two_oe_n <= 1'b1;
            paused             <= RST_PAUSED;
            selected           <= RST_SEL;
            iface_reset        <= 1'b0;
            status_wr_ok       <= 1'b0;
            fast_program_ok    <= 1'b0;
        end else begin
            state_r            <= state_nxt;
            shift_r            <= shift_nxt;
            bit_valid          <= bv_nxt;
            so_out             <= so_nxt;
            so_oe_n            <= so_oe_n_nxt;
            data_line_two_oe_n <= io2_oe_n_nxt;
            paused             <= (state_nxt == SHP_PAUSED);
            selected           <= (state_nxt != SHP_IDLE);
            iface_reset        <= rst_pulse_nxt;
            status_wr_ok       <= wr_ok_nxt;
            fast_program_ok    <= fp_ok_nxt;
        end
    end
    assign shift_data = shift_r;

    // ****************************************
    // checks
    // ****************************************
    chk_pause_needs_cs: assert property (@(posedge clk) disable iff (rst)
        state_nxt == SHP_PAUSED |-> !s2_r.cs_n)
        else $error("pause held with chip select high");
    chk_wp_blocks: assert property (@(posedge clk) disable iff (rst)
        status_wr_req && !s2_r.wp_n && !mode.quad_enable_bit |=> !status_wr_ok)
        else $error("status write passed while protected");
    chk_qe_frees_wp: assert property (@(posedge clk) disable iff (rst)
        status_wr_req && mode.quad_enable_bit |=> status_wr_ok)
        else $error("quad mode did not free protection");
    chk_fast_prog_gate: assert property (@(posedge clk) disable iff (rst)
        mode.four_line_command_mode |=> !fast_program_ok)
        else $error("fast program in four-line mode");
    chk_pause_entry: assert property (@(posedge clk) disable iff (rst)
        state_r == SHP_ACTIVE && state_nxt == SHP_PAUSED |-> hold_fall && !s2_r.sck)
        else $error("pause entered without low clock");
    chk_pause_exit: assert property (@(posedge clk) disable iff (rst)
        state_r == SHP_PAUSED && state_nxt == SHP_ACTIVE |-> hold_rise && !s2_r.sck)
        else $error("pause left without low clock");
    chk_cs_reset: assert property (@(posedge clk) disable iff (rst)
        state_r == SHP_PAUSED && s2_r.cs_n |=> iface_reset && !paused)
        else $error("no reset on deselect while paused");
    chk_pause_frozen: assert property (@(posedge clk) disable iff (rst)
        paused && state_r == SHP_PAUSED && !s2_r.cs_n |=> $stable(shift_r))
        else $error("shifter moved while paused");
    chk_desel_float: assert property (@(posedge clk) disable iff (rst)
        !selected |-> so_oe_n)
        else $error("output driven while deselected");
    chk_pause_float: assert property (@(posedge clk) disable iff (rst)
        paused |-> so_oe_n && data_line_two_oe_n && !bit_valid)
        else $error("activity while paused");
endmodule

/* File: rtl/shp_pkg.sv */
// package for the serial flash pause and write-protect control block
package shp_pkg;
    // ****************************************
    // constants
    // ****************************************
    localparam int SYNC_STAGES = 2;
    localparam logic RST_PAUSED = 1'b0;
    localparam logic RST_SEL    = 1'b0;
    localparam logic RST_QE     = 1'b0;
    localparam logic RST_QPI    = 1'b0;
    localparam int   SHIFT_W    = 8;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [1:0] {
        SHP_IDLE,
        SHP_ACTIVE,
        SHP_PAUSED
    } shp_state_e;

    // pin levels after synchronisation
    typedef struct packed {
        logic cs_n;
        logic sck;
        logic pause_n;
        logic wp_n;
        logic si;
    } shp_pins_s;

    // mode bits from the status/command logic
    typedef struct packed {
        logic quad_enable_bit;
        logic four_line_command_mode;
    } shp_mode_s;

    // pin idle levels: deselected, clock low, pause and protect released
    localparam shp_pins_s RST_PINS = 5'h16;
endpackage

/* File: sim/shp_host.sv */
// host side model that drives the flash port pins
module shp_host
    import shp_pkg::*;
(
    // clock
    input  wire logic          clk,
    // pins toward the port
    output shp_pkg::shp_pins_s pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // ****************************************
    // pin sequencing, half link period 80 ns
    // ****************************************
    initial pins = 5'h16;
    task automatic hold_half();
        repeat (10) @(negedge clk);
    endtask
    task automatic set_cs(input logic v);
        pins.cs_n = v;
        pins.si = ~pins.si;
        hold_half();
    endtask
    // data and protect levels change with no wait of their own
    task automatic set_si(input logic v);
        pins.si = v;
    endtask
    task automatic set_wp(input logic v);
        pins.wp_n = v;
    endtask
    task automatic set_sck(input logic v);
        pins.sck = v;
        hold_half();
    endtask
    // callers keep sck low here unless a refusal is meant
    task automatic set_pause(input logic v);
        pins.pause_n = v;
        hold_half();
    endtask
endmodule

/* File: sim/shp_ctrl_test.sv */
// self-checking bench for the pause and write-protect block
module shp_ctrl_test;
    timeunit 1ns;
    timeprecision 1ps;
    import shp_pkg::*;
    // ****************************************
    // signals
    // ****************************************
    logic       clk = 1'b0;
    logic       rst;
    shp_pins_s  pins;
    shp_mode_s  mode;
    logic       wr_req;
    logic       fast_pin;
    logic       out_bit;
    logic       so_out, so_oe_n, dl2_oe_n, paused, selected, iface_reset;
    logic       status_wr_ok, fast_program_ok, bit_valid;
    logic       rst_seen;
    logic [7:0] shift_data;
    logic [7:0] shadow;
    logic [7:0] exp_q[$];
    int         error_cnt = 0, samples_checked = 0;

    initial forever #4 clk = ~clk;

    shp_host host_inst (.clk(clk), .pins(pins));
    shp_ctrl shp_ctrl_inst (.clk(clk), .rst(rst), .pins(pins), .mode(mode),
        .status_wr_req(wr_req), .fast_program_supply_pin(fast_pin),
        .out_bit(out_bit), .so_out(so_out), .so_oe_n(so_oe_n),
        .data_line_two_oe_n(dl2_oe_n), .paused(paused), .selected(selected),
        .iface_reset(iface_reset), .status_wr_ok(status_wr_ok),
        .fast_program_ok(fast_program_ok), .bit_valid(bit_valid),
        .shift_data(shift_data));
    // ****************************************
    // compare and closing tasks
    // ****************************************
    task automatic chk1(input string n, input logic e, input logic g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic chk8(input string n, input logic [7:0] e,
                        input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // note the expected shifter before the edge that makes it
    task automatic rise(input logic b);
        host_inst.set_si(b);
        shadow = {shadow[6:0], b};
        exp_q.push_back(shadow);
        host_inst.set_sck(1'b1);
    endtask
    // next output bit stands before the falling clock that moves it out
    task automatic send(input logic b);
        logic ob;
        rise(b);
        ob = 1'($urandom);
        out_bit = ob;
        host_inst.set_sck(1'b0);
        chk1("so_out", ob, so_out);
        chk1("so_oe_n active", 1'b0, so_oe_n);
    endtask
    // ****************************************
    // output watcher; a pulse with no note is a stray bit
    // ****************************************
    // sampled at the falling edge, where registered outputs have settled
    always @(negedge clk) begin
        if (bit_valid === 1'b1) begin
            if (exp_q.size() == 0) chk1("stray bit", 1'b0, 1'b1);
            else chk8("shift", exp_q.pop_front(), shift_data);
        end
        if (iface_reset === 1'b1) rst_seen = 1'b1;
    end
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst      = 1'b1;
        mode     = '0;
        wr_req   = 1'b0;
        fast_pin = 1'b0;
        out_bit  = 1'b0;
        rst_seen = 1'b0;
        shadow   = 8'h00;
        void'($urandom(17394));
        repeat (8) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        chk1("so_oe_n idle", 1'b1, so_oe_n);
        host_inst.set_cs(1'b0);
        chk1("selected", 1'b1, selected);
        repeat (8) send(1'($urandom));
        host_inst.set_pause(1'b0);
        chk1("paused", 1'b1, paused);
        chk1("so_oe_n paused", 1'b1, so_oe_n);
        host_inst.set_sck(1'b1);
        host_inst.set_sck(1'b0);
        chk1("still paused", 1'b1, paused);
        host_inst.set_pause(1'b1);
        chk1("resumed", 1'b0, paused);
        send(1'($urandom));
        rise(1'($urandom));
        host_inst.set_pause(1'b0);
        chk1("pause sck high", 1'b0, paused);
        host_inst.set_pause(1'b1);
        host_inst.set_sck(1'b0);
        host_inst.set_cs(1'b1);
        chk1("so_oe_n deselect", 1'b1, so_oe_n);
        host_inst.set_pause(1'b0);
        chk1("pause cs high", 1'b0, paused);
        host_inst.set_pause(1'b1);
        host_inst.set_cs(1'b0);
        host_inst.set_pause(1'b0);
        chk1("paused again", 1'b1, paused);
        host_inst.set_cs(1'b1);
        chk1("iface reset", 1'b1, rst_seen);
        chk1("pause dropped", 1'b0, paused);
        host_inst.set_pause(1'b1);
        host_inst.set_cs(1'b0);
        chk1("reselected", 1'b1, selected);
        shadow = 8'h00;
        repeat (8) send(1'($urandom));
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            mode.quad_enable_bit = i[1];
            host_inst.set_wp(i[0]);
            wr_req = i[2];
            repeat (6) @(negedge clk);
            chk1("wr grant", i[2] & (i[0] | i[1]), status_wr_ok);
            chk1("dl2_oe_n", ~i[1], dl2_oe_n);
        end
        host_inst.set_pause(1'b0);
        chk1("pause quad", 1'b0, paused);
        host_inst.set_pause(1'b1);
        wr_req = 1'b0;
        mode.quad_enable_bit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            fast_pin = i[1];
            mode.four_line_command_mode = i[0];
            repeat (4) @(negedge clk);
            chk1("fast grant", i[1] & !i[0], fast_program_ok);
        end
        host_inst.set_pause(1'b0);
        chk1("pause four-line", 1'b0, paused);
        host_inst.set_pause(1'b1);
        close_out();
    end
endmodule
